// [rtl/tcu_pkg.sv]
package tcu_pkg;

    // Wishbone byte addresses of the register words
    localparam logic [4:0] ADR_TIMER_CONTROL = 5'h00;
    localparam logic [4:0] ADR_IO_CONTROL = 5'h04;
    localparam logic [4:0] ADR_COUNT = 5'h08;
    localparam logic [4:0] ADR_GEN_A = 5'h0C;
    localparam logic [4:0] ADR_GEN_B = 5'h10;
    localparam logic [4:0] ADR_GEN_C = 5'h14;
    localparam logic [4:0] ADR_GEN_D = 5'h18;
    localparam logic [4:0] ADR_STATUS = 5'h1C;

    localparam logic [2:0] CKS_DIV1 = 3'h0;
    localparam logic [2:0] CKS_DIV2 = 3'h1;
    localparam logic [2:0] CKS_DIV4 = 3'h2;
    localparam logic [2:0] CKS_DIV8 = 3'h3;

    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;

    localparam logic [1:0] CAP_RISE = 2'h0;
    localparam logic [1:0] CAP_FALL = 2'h1;

    localparam int IO_RSV_BIT = 3;
    localparam int STATUS_W = 6;

    typedef struct packed {
        logic clear_on_match_a;
        logic [2:0] count_clock_select;
        logic init_level_d;
        logic init_level_c;
        logic init_level_b;
        logic rsv0;
    } timer_control_s;

    typedef struct packed {
        logic rsv7;
        logic channel_b_function;
        logic [1:0] channel_b_ctrl;
        logic rsv3;
        logic channel_a_function;
        logic [1:0] channel_a_ctrl;
    } io_control_s;

    localparam timer_control_s TCR_RESET = 8'h00;
    localparam io_control_s IOC_RESET = 8'h08;

endpackage : tcu_pkg

// [rtl/timer_capture_compare_unit.sv]
`timescale 1ns/100ps
// Overview of operation
// - Clear bit set: match A zeroes counter while A is a compare register
// - Select 000..011: clock, /2, /4, /8
// - Select 1XX: count external event rising edges
// - Undivided clock counts subclock in sub modes
// - Init level D drives D until match
// - Init level C drives C until match
// - Init level B drives B until match
// - B compare: none, low, high, toggle
// - B capture: rising, falling, both edges
// - A function bit: compare or capture
// - I/O control bit 3 reads one
// - A compare: none, low, high, toggle
// - A capture: rising, falling, both edges
module timer_capture_compare_unit
    import tcu_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic cyc,
    input wire logic stb,
    input wire logic we,
    input wire logic [4:0] adr,
    input wire logic [3:0] sel,
    input wire logic [31:0] wdata,
    output logic [31:0] rdata,
    output logic ack,
    input wire logic sub_mode,
    input wire logic sub_tick,
    input wire logic external_event_pin,
    input wire logic channel_a_pin_in,
    output logic channel_a_pin_out,
    output logic channel_a_pin_oe,
    input wire logic channel_b_pin_in,
    output logic channel_b_pin_out,
    output logic channel_b_pin_oe,
    output logic channel_c_pin,
    output logic channel_d_pin
);

    if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
        $error("CNT_W must lie between 2 and 16");
    end

    timer_control_s tcr_reg;
    io_control_s ioc_reg;
    logic [CNT_W-1:0] count_reg, gra_reg, grb_reg, grc_reg, grd_reg;
    logic [STATUS_W-1:0] status_reg;
    logic [2:0] presc_reg;
    logic ext_prev_reg, a_prev_reg, b_prev_reg;
    logic seen_b_reg, seen_c_reg, seen_d_reg;
    logic ack_reg, a_out_reg, b_out_reg, c_out_reg, d_out_reg, a_oe_reg, b_oe_reg;
    logic [31:0] rdata_reg;

    function automatic logic [CNT_W-1:0] merge(input logic [CNT_W-1:0] old, input logic [31:0] d,
                                               input logic [3:0] s);
        logic [15:0] v;
        v = 16'(old);
        if (s[0]) begin
            v[7:0] = d[7:0];
        end
        if (s[1]) begin
            v[15:8] = d[15:8];
        end
        return v[CNT_W-1:0];
    endfunction : merge

    function automatic logic out_act(input logic [1:0] ctrl, input logic cur);
        unique case (ctrl)
            ACT_NONE: return cur;
            ACT_LOW: return 1'b0;
            ACT_HIGH: return 1'b1;
            ACT_TOGGLE: return ~cur;
        endcase
    endfunction : out_act

    function automatic logic cap_hit(input logic [1:0] ctrl, input logic rise, input logic fall);
        if (ctrl[1]) begin
            return rise | fall;
        end
        return (ctrl == CAP_FALL) ? fall : rise;
    endfunction : cap_hit

    logic req, wr, rd;
    assign req = cyc && stb && !ack_reg;
    assign wr = req && we;
    assign rd = req && !we;

    logic wr_tcr, wr_ioc, wr_cnt, wr_gra, wr_grb, wr_grc, wr_grd, wr_st;
    assign wr_tcr = wr && adr == ADR_TIMER_CONTROL && sel[0];
    assign wr_ioc = wr && adr == ADR_IO_CONTROL && sel[0];
    assign wr_cnt = wr && adr == ADR_COUNT && |sel[1:0];
    assign wr_gra = wr && adr == ADR_GEN_A && |sel[1:0];
    assign wr_grb = wr && adr == ADR_GEN_B && |sel[1:0];
    assign wr_grc = wr && adr == ADR_GEN_C && |sel[1:0];
    assign wr_grd = wr && adr == ADR_GEN_D && |sel[1:0];
    assign wr_st = wr && adr == ADR_STATUS && sel[0];

    // Count tick source
    logic ext_rise, tick;
    assign ext_rise = external_event_pin && !ext_prev_reg;
    always_comb begin
        if (tcr_reg.count_clock_select[2]) begin
            tick = ext_rise;
        end else begin
            unique case (tcr_reg.count_clock_select[1:0])
                CKS_DIV1[1:0]: tick = sub_mode ? sub_tick : 1'b1;
                CKS_DIV2[1:0]: tick = presc_reg[0];
                CKS_DIV4[1:0]: tick = &presc_reg[1:0];
                CKS_DIV8[1:0]: tick = &presc_reg;
            endcase
        end
    end

    // Prescaler is cleared only by reset, so the first divided tick after a select change may come early
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            presc_reg <= 3'h0;
            ext_prev_reg <= 1'b0;
            a_prev_reg <= 1'b0;
            b_prev_reg <= 1'b0;
        end else begin
            presc_reg <= presc_reg + 3'h1;
            ext_prev_reg <= external_event_pin;
            a_prev_reg <= channel_a_pin_in;
            b_prev_reg <= channel_b_pin_in;
        end
    end

    // Match and capture events
    // A capture stores the count held before this edge's increment
    logic m_a, m_b, m_c, m_d, cap_a, cap_b;
    assign m_a = tick && count_reg == gra_reg;
    assign m_b = tick && count_reg == grb_reg;
    assign m_c = tick && count_reg == grc_reg;
    assign m_d = tick && count_reg == grd_reg;
    assign cap_a = ioc_reg.channel_a_function
                   && cap_hit(ioc_reg.channel_a_ctrl, channel_a_pin_in && !a_prev_reg,
                              !channel_a_pin_in && a_prev_reg);
    assign cap_b = ioc_reg.channel_b_function
                   && cap_hit(ioc_reg.channel_b_ctrl, channel_b_pin_in && !b_prev_reg,
                              !channel_b_pin_in && b_prev_reg);

    // Compare A only clears while A is a compare register
    logic clr_hit;
    assign clr_hit = m_a && tcr_reg.clear_on_match_a && !ioc_reg.channel_a_function;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tcr_reg <= TCR_RESET;
            ioc_reg <= IOC_RESET;
        end else begin
            if (wr_tcr) begin
                tcr_reg <= timer_control_s'({wdata[7:1], 1'b0});
            end
            if (wr_ioc) begin
                ioc_reg <= io_control_s'({1'b0, wdata[6:4], 1'b1, wdata[2:0]});
            end
        end
    end

    // Software write to the counter wins over a tick in the same cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_reg <= '0;
        end else if (wr_cnt) begin
            count_reg <= merge(count_reg, wdata, sel);
        end else if (clr_hit) begin
            count_reg <= '0;
        end else if (tick) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // A capture edge beats a software write in the same cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            gra_reg <= '1;
            grb_reg <= '1;
            grc_reg <= '1;
            grd_reg <= '1;
        end else begin
            if (cap_a) begin
                gra_reg <= count_reg;
            end else if (wr_gra) begin
                gra_reg <= merge(gra_reg, wdata, sel);
            end
            if (cap_b) begin
                grb_reg <= count_reg;
            end else if (wr_grb) begin
                grb_reg <= merge(grb_reg, wdata, sel);
            end
            if (wr_grc) begin
                grc_reg <= merge(grc_reg, wdata, sel);
            end
            if (wr_grd) begin
                grd_reg <= merge(grd_reg, wdata, sel);
            end
        end
    end

    // Sticky event flags, write one to clear; a new event wins over the clear
    logic [STATUS_W-1:0] ev;
    assign ev = {cap_b, cap_a, m_d, m_c, m_b && !ioc_reg.channel_b_function,
                 m_a && !ioc_reg.channel_a_function};
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_reg <= '0;
        end else begin
            status_reg <= (status_reg & ~(wr_st ? wdata[STATUS_W-1:0] : '0)) | ev;
        end
    end

    // Pin levels: the init level holds until the first match of its channel
    // Channel A has no init bit, so it idles low until its first match
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            seen_b_reg <= 1'b0;
            seen_c_reg <= 1'b0;
            seen_d_reg <= 1'b0;
            a_out_reg <= 1'b0;
            b_out_reg <= 1'b0;
            c_out_reg <= 1'b0;
            d_out_reg <= 1'b0;
            a_oe_reg <= 1'b0;
            b_oe_reg <= 1'b0;
        end else begin
            a_oe_reg <= !ioc_reg.channel_a_function;
            b_oe_reg <= !ioc_reg.channel_b_function;
            if (m_a && !ioc_reg.channel_a_function) begin
                a_out_reg <= out_act(ioc_reg.channel_a_ctrl, a_out_reg);
            end
            if (m_b && !ioc_reg.channel_b_function) begin
                seen_b_reg <= 1'b1;
                b_out_reg <= out_act(ioc_reg.channel_b_ctrl, b_out_reg);
            end else if (!seen_b_reg) begin
                b_out_reg <= tcr_reg.init_level_b;
            end
            // Channels C and D have no control field here; a match toggles them
            if (m_c) begin
                seen_c_reg <= 1'b1;
                c_out_reg <= ~c_out_reg;
            end else if (!seen_c_reg) begin
                c_out_reg <= tcr_reg.init_level_c;
            end
            if (m_d) begin
                seen_d_reg <= 1'b1;
                d_out_reg <= ~d_out_reg;
            end else if (!seen_d_reg) begin
                d_out_reg <= tcr_reg.init_level_d;
            end
        end
    end

    // Bus answer one cycle after the request; unmapped words read zero
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            ack_reg <= req;
            if (rd) begin
                unique case (adr)
                    ADR_TIMER_CONTROL: rdata_reg <= {24'h0, tcr_reg};
                    ADR_IO_CONTROL: rdata_reg <= {24'h0, ioc_reg};
                    ADR_COUNT: rdata_reg <= 32'(count_reg);
                    ADR_GEN_A: rdata_reg <= 32'(gra_reg);
                    ADR_GEN_B: rdata_reg <= 32'(grb_reg);
                    ADR_GEN_C: rdata_reg <= 32'(grc_reg);
                    ADR_GEN_D: rdata_reg <= 32'(grd_reg);
                    ADR_STATUS: rdata_reg <= 32'(status_reg);
                    default: rdata_reg <= 32'h0;
                endcase
            end
        end
    end

    assign ack = ack_reg;
    assign rdata = rdata_reg;
    assign channel_a_pin_out = a_out_reg;
    assign channel_a_pin_oe = a_oe_reg;
    assign channel_b_pin_out = b_out_reg;
    assign channel_b_pin_oe = b_oe_reg;
    assign channel_c_pin = c_out_reg;
    assign channel_d_pin = d_out_reg;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    AST_CLEAR_A: assert property (clr_hit && !wr_cnt |=> count_reg == '0)
        else $error("counter not cleared on match A");
    // Reset is sampled low at its release edge, where the counter still loads zero
    AST_FREE_RUN: assert property (arst_n && tick && !clr_hit && !wr_cnt
                                   |=> count_reg == $past(count_reg) + 1'b1)
        else $error("counter did not advance on tick");
    // A select change inside the window ends the spacing check
    AST_DIV8: assert property (tcr_reg.count_clock_select == CKS_DIV8 && tick
                               |=> (tcr_reg.count_clock_select != CKS_DIV8 || !tick)[*7]
                               ##1 (tcr_reg.count_clock_select != CKS_DIV8 || tick))
        else $error("divide by eight tick spacing wrong");
    AST_EXT: assert property (tcr_reg.count_clock_select[2] && !ext_rise |-> !tick)
        else $error("tick without external rising edge");
    AST_SUB: assert property (tcr_reg.count_clock_select == CKS_DIV1 && sub_mode && !sub_tick |-> !tick)
        else $error("system clock counted in sub mode");
    AST_INIT_D: assert property (!seen_d_reg && !m_d |=> channel_d_pin == $past(tcr_reg.init_level_d))
        else $error("pin D not at init level");
    AST_INIT_C: assert property (!seen_c_reg && !m_c |=> channel_c_pin == $past(tcr_reg.init_level_c))
        else $error("pin C not at init level");
    AST_INIT_B: assert property (!seen_b_reg && !m_b |=> channel_b_pin_out == $past(tcr_reg.init_level_b))
        else $error("pin B not at init level");
    AST_B_LOW: assert property (m_b && !ioc_reg.channel_b_function && ioc_reg.channel_b_ctrl == ACT_LOW
                                |=> !channel_b_pin_out)
        else $error("pin B not driven low on match");
    AST_B_HIGH: assert property (m_b && !ioc_reg.channel_b_function && ioc_reg.channel_b_ctrl == ACT_HIGH
                                 |=> channel_b_pin_out)
        else $error("pin B not driven high on match");
    AST_B_CAP: assert property (cap_b |=> grb_reg == $past(count_reg))
        else $error("capture B lost");
    AST_A_OE: assert property (ioc_reg.channel_a_function |=> !channel_a_pin_oe)
        else $error("pin A driven in capture mode");
    AST_RSV: assert property (rd && adr == ADR_IO_CONTROL |=> ack && rdata[IO_RSV_BIT])
        else $error("reserved bit not read as one");
    AST_A_TOG: assert property (m_a && !ioc_reg.channel_a_function && ioc_reg.channel_a_ctrl == ACT_TOGGLE
                                |=> channel_a_pin_out != $past(channel_a_pin_out))
        else $error("pin A did not toggle");
    AST_A_CAP: assert property (ioc_reg.channel_a_function && ioc_reg.channel_a_ctrl == CAP_FALL
                                && channel_a_pin_in && !a_prev_reg |=> gra_reg != $past(count_reg) || $past(wr_gra)
                                || $past(gra_reg) == $past(count_reg))
        else $error("rising edge captured in falling mode");
    AST_A_CAP_HIT: assert property (cap_a |=> gra_reg == $past(count_reg))
        else $error("capture A lost");
    AST_RESET: assert property ($rose(arst_n) |-> tcr_reg == TCR_RESET)
        else $error("control not at reset value");

    COV_CLEAR: cover property (clr_hit);
    COV_CAP_B: cover property (cap_b);
    COV_CAP_A: cover property (cap_a);
    COV_EXT: cover property (tcr_reg.count_clock_select[2] && tick);
    COV_TOG_B: cover property (m_b && ioc_reg.channel_b_ctrl == ACT_TOGGLE && !ioc_reg.channel_b_function);

endmodule : timer_capture_compare_unit

// [testbench/pin_partner.sv]
`timescale 1ns/100ps
// Stands on the far side of the channel and event pins
module pin_partner (
    input wire logic core_clk,
    input wire logic channel_a_pin_out,
    input wire logic channel_a_pin_oe,
    input wire logic channel_b_pin_out,
    input wire logic channel_b_pin_oe,
    output logic channel_a_pin_in,
    output logic channel_b_pin_in,
    output logic external_event_pin
);
    logic a_drv = 1'b0;
    logic b_drv = 1'b0;

    initial external_event_pin = 1'b0;

    // The wire follows the timer while it drives, our level otherwise
    assign channel_a_pin_in = channel_a_pin_oe ? channel_a_pin_out : a_drv;
    assign channel_b_pin_in = channel_b_pin_oe ? channel_b_pin_out : b_drv;

    // Pulses are held two edges high and four low between pulses, slower than the clock
    task automatic pulse_event(input int n);
        repeat (n) begin
            @(posedge core_clk);
            external_event_pin <= 1'b1;
            repeat (2) @(posedge core_clk);
            external_event_pin <= 1'b0;
            repeat (3) @(posedge core_clk);
        end
    endtask : pulse_event

    task automatic set_pins(input logic v);
        @(posedge core_clk);
        a_drv <= v;
        b_drv <= v;
    endtask : set_pins
endmodule : pin_partner

// [testbench/tb_timer_capture_compare_unit.sv]
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_timer_capture_compare_unit;
    import tcu_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] q;
    logic ack;
    logic sub_mode = 1'b0;
    logic sub_tick = 1'b0;
    logic ev, a_in, a_out, a_oe, b_in, b_out, b_oe, c_pin, d_pin;
    logic [1:0] pin_exp [4] = '{2'b10, 2'b00, 2'b11, 2'b00};
    int failures = 0;
    int n_compared = 0;

    always #25 core_clk = ~core_clk;

    timer_capture_compare_unit #(.CNT_W(16)) dut (
        .core_clk(core_clk), .arst_n(arst_n), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
        .wdata(wdata), .rdata(rdata), .ack(ack), .sub_mode(sub_mode), .sub_tick(sub_tick),
        .external_event_pin(ev), .channel_a_pin_in(a_in), .channel_a_pin_out(a_out),
        .channel_a_pin_oe(a_oe), .channel_b_pin_in(b_in), .channel_b_pin_out(b_out),
        .channel_b_pin_oe(b_oe), .channel_c_pin(c_pin), .channel_d_pin(d_pin)
    );

    pin_partner part (
        .core_clk(core_clk), .channel_a_pin_out(a_out), .channel_a_pin_oe(a_oe),
        .channel_b_pin_out(b_out), .channel_b_pin_oe(b_oe), .channel_a_pin_in(a_in),
        .channel_b_pin_in(b_in), .external_event_pin(ev)
    );

    // The request stands until ack is sampled high; read data is taken at that same edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdata <= d;
        sel <= 4'h3;
        do @(posedge core_clk); while (ack !== 1'b1);
        q = rdata;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask : settle

    task automatic do_reset();
        @(posedge core_clk);
        arst_n <= 1'b0;
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
    endtask : do_reset

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        report_and_stop();
    end

    initial begin
        do_reset();
        settle(2);
        `CHK("pins bcd", 3'b000, {b_out, c_pin, d_pin})
        bus(1'b0, ADR_TIMER_CONTROL, 32'h0);
        `CHK("timer_control", 8'h00, q[7:0])
        bus(1'b1, ADR_IO_CONTROL, 32'h0);
        bus(1'b0, ADR_IO_CONTROL, 32'h0);
        `CHK("io_control", 8'h08, q[7:0])
        bus(1'b1, ADR_TIMER_CONTROL, 32'h0E);
        settle(2);
        `CHK("pin b init", 1'b1, b_out)
        `CHK("pin c init", 1'b1, c_pin)
        `CHK("pin d init", 1'b1, d_pin)
        bus(1'b1, ADR_GEN_A, 32'h20);
        bus(1'b1, ADR_GEN_B, 32'h20);
        // Pin B starts at its initial level 1, pin A at 0; each action is applied once
        for (int act = 0; act < 4; act++) begin
            bus(1'b1, ADR_IO_CONTROL, {24'h0, 2'b00, 2'(act), 2'b00, 2'(act)});
            bus(1'b1, ADR_COUNT, 32'h0);
            settle(48);
            `CHK("pin a compare", pin_exp[act][0], a_out)
            `CHK("pin b compare", pin_exp[act][1], b_out)
        end
        bus(1'b1, ADR_GEN_A, 32'h10);
        bus(1'b1, ADR_TIMER_CONTROL, 32'h80);
        bus(1'b1, ADR_COUNT, 32'h0);
        settle(40);
        bus(1'b0, ADR_COUNT, 32'h0);
        `CHK("count cleared", 1'b1, q <= 32'h10)
        // Prescaler phase is unknown, so each divided count gets a window
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, ADR_TIMER_CONTROL, 32'(s << 4));
            bus(1'b1, ADR_COUNT, 32'h0);
            repeat (64) @(posedge core_clk);
            bus(1'b0, ADR_COUNT, 32'h0);
            `CHK("count divided", 1'b1, q >= 32'(64 >> s) && q <= 32'((72 >> s) + 1))
        end
        for (int s = 4; s < 8; s += 3) begin
            bus(1'b1, ADR_TIMER_CONTROL, 32'(s << 4));
            bus(1'b1, ADR_COUNT, 32'h0);
            part.pulse_event(5);
            bus(1'b0, ADR_COUNT, 32'h0);
            `CHK("count events", 32'h5, q)
        end
        bus(1'b1, ADR_TIMER_CONTROL, 32'h0);
        @(posedge core_clk);
        sub_mode <= 1'b1;
        bus(1'b1, ADR_COUNT, 32'h0);
        repeat (3) begin
            @(posedge core_clk);
            sub_tick <= 1'b1;
            @(posedge core_clk);
            sub_tick <= 1'b0;
            repeat (3) @(posedge core_clk);
        end
        bus(1'b0, ADR_COUNT, 32'h0);
        `CHK("count sub ticks", 32'h3, q)
        sub_mode <= 1'b0;
        // Pins C and D sit at init level 0; one match toggles them and they must not fall back
        bus(1'b1, ADR_GEN_C, 32'h40);
        bus(1'b1, ADR_GEN_D, 32'h40);
        bus(1'b1, ADR_COUNT, 32'h0);
        settle(80);
        `CHK("pins cd after match", 2'b11, {c_pin, d_pin})
        for (int m = 0; m < 3; m++) begin
            bus(1'b1, ADR_IO_CONTROL, {24'h0, 2'b01, 2'(m), 2'b01, 2'(m)});
            settle(1);
            `CHK("oe a", 1'b0, a_oe)
            `CHK("oe b", 1'b0, b_oe)
            bus(1'b1, ADR_STATUS, 32'h30);
            part.set_pins(1'b1);
            settle(3);
            bus(1'b0, ADR_STATUS, 32'h0);
            `CHK("capture rise", (m != 1) ? 2'b11 : 2'b00, q[5:4])
            bus(1'b1, ADR_STATUS, 32'h30);
            part.set_pins(1'b0);
            settle(3);
            bus(1'b0, ADR_STATUS, 32'h0);
            `CHK("capture fall", (m != 0) ? 2'b11 : 2'b00, q[5:4])
        end
        bus(1'b0, 5'h1E, 32'h0);
        bus(1'b1, ADR_IO_CONTROL, 32'hF7);
        bus(1'b0, ADR_IO_CONTROL, 32'h0);
        `CHK("io_control rsv", 8'h7F, q[7:0])
        bus(1'b1, ADR_TIMER_CONTROL, 32'hFF);
        do_reset();
        bus(1'b0, ADR_TIMER_CONTROL, 32'h0);
        `CHK("timer_control rst", 8'h00, q[7:0])
        bus(1'b0, ADR_IO_CONTROL, 32'h0);
        `CHK("io_control rst", 8'h08, q[7:0])
        report_and_stop();
    end
endmodule : tb_timer_capture_compare_unit
